// ### core/clkctl_params.svh
// register map, field positions, reset values and counts of the clock-divide controller
`ifndef CLKCTL_PARAMS_SVH
`define CLKCTL_PARAMS_SVH
// ****************************************
// register offsets
// ****************************************
`define PMR_OFS 8'hC4
`define STATUS_OFS 8'hC5
`define MEM_CFG_OFS 8'hC6
`define KEY_OFS 8'hC7
`define IRQ_STAT_OFS 8'hD1
`define IRQ_CLR_OFS 8'hD2
`define IRQ_EN_OFS 8'hD3
// ****************************************
// field positions
// ****************************************
`define PMR_CD_HI 7
`define PMR_CD_LO 6
`define PMR_SB_EN 5
`define PMR_XT_DIS 3
`define PMR_OSC 2
`define ST_XT_RDY 4
`define ST_TX1 3
`define ST_RX1 2
`define ST_TX0 1
`define ST_RX0 0
`define MEM_WAIT_EN 7
`define IRQ_SB 0
`define IRQ_XT_RDY 1
`define IRQ_REFUSE 2
// ****************************************
// codes, reset values and counts
// ****************************************
`define CD_RSVD 2'h0
`define CD_DIV4 2'h1
`define CD_DIV64 2'h2
`define CD_DIV1024 2'h3
`define MC_LAST4 10'h003
`define MC_LAST64 10'h03F
`define MC_LAST1024 10'h3FF
`define KEY_FIRST 8'hAA
`define KEY_SECOND 8'h55
`define KEY_WIN_MC 2'h3
`define XT_WARMUP_CYC 16'h0400
`define IRQ_W 3
`endif

// ### core/clkctl_pkg.sv
// types shared by the clock-divide controller
package clkctl_pkg;
   typedef enum logic [1:0]
   {
      UNLOCK_IDLE = 2'b00,
      UNLOCK_ARMED = 2'b01,
      UNLOCK_OPEN = 2'b11
   } unlock_state_e;
endpackage

// ### core/clock_divide_switchback_ctrl.sv
// clock divide, switchback, crystal control and timed-access protection
// Overview of operation
// RULE1: divide code sets 4, 64, 1024 clocks
// RULE2: software goes via divide-by-4 between slow settings
// RULE3: switchback forces divide code back to 01
// RULE4: external interrupt switchback at vector jump
// RULE5: receive switchback at next instruction start
// RULE6: crystal disable accepted only on RC
// RULE7: crystal restart, ready after warm-up
// RULE8: ready cleared on each crystal restart
// RULE9: ready reads one after reset
// RULE10: no crystal select while not ready
// RULE11: transmit activity until transmit done
// RULE12: receive activity until receive done
// RULE13: divide writes ignored during serial activity; the code ignores them only while switchback is enabled
// RULE14: software writes AA then 55 key
// RULE15: key opens three machine cycle window
// RULE16: wait-state enable writable only in window
// RULE17: protected bits kept outside window, broken key
`timescale 1ns/1ns
`include "clkctl_params.svh"
module clock_divide_switchback_ctrl
   import clkctl_pkg::*;
(
   // clock and reset
   input wire logic I_SYS_CLK,
   input wire logic I_RST_N,
   // register port
   input wire logic [7:0] I_ADDR,
   input wire logic [7:0] I_WDATA,
   input wire logic I_WR,
   input wire logic I_RD,
   output logic [7:0] O_RDATA,
   // core events
   input wire logic I_EXT_INT_VECTOR,
   input wire logic I_EXT_INT_EN,
   input wire logic I_INSTR_START,
   input wire logic I_PD_EXIT,
   // serial port events
   input wire logic I_UART0_TX_START,
   input wire logic I_UART0_RX_START,
   input wire logic I_UART0_TX_DONE_FLAG,
   input wire logic I_UART0_RX_DONE_FLAG,
   input wire logic I_UART1_TX_START,
   input wire logic I_UART1_RX_START,
   input wire logic I_UART1_TX_DONE_FLAG,
   input wire logic I_UART1_RX_DONE_FLAG,
   // clock control outputs
   output logic [1:0] O_CLK_DIV_SEL,
   output logic O_MC_TICK,
   output logic O_XTAL_EN,
   output logic O_OSC_SOURCE_SEL,
   output logic O_CRYSTAL_READY,
   output logic O_WAIT_STATE_EN,
   output logic O_UNLOCK_WINDOW,
   output logic O_IRQ
);

   // ****************************************
   // declarations
   // ****************************************
   logic [1:0] clk_div_q;
   logic switchback_en_q;
   logic crystal_disable_q;
   logic osc_source_sel_q;
   logic crystal_ready_q;
   logic wait_state_en_q;
   logic [3:0] act_q;
   logic rx_pend_q;
   logic [9:0] mc_cnt_q;
   logic [15:0] wu_cnt_q;
   unlock_state_e unlock_q;
   logic [1:0] unlock_left_q;
   logic [`IRQ_W-1:0] irq_stat_q;
   logic [`IRQ_W-1:0] irq_en_q;
   logic [7:0] rdata_q;
   logic mc_tick;
   logic any_act;
   logic sb_int;
   logic sb_tx;
   logic sb_rx;
   logic sb_any;
   logic pmr_wr;
   logic key_wr;
   logic cfg_wr;
   logic div_wr_ok;
   logic xtal_off_set;
   logic xt_restart;
   logic ready_rise;
   logic wait_refused;
   logic [`IRQ_W-1:0] irq_evt;

   function automatic logic [9:0] mc_last(input logic [1:0] code);
      logic [9:0] last;
      last = `MC_LAST4;
      unique case (code)
         `CD_DIV64: last = `MC_LAST64;
         `CD_DIV1024: last = `MC_LAST1024;
         default: last = `MC_LAST4;
      endcase
      return last;
   endfunction

   // ****************************************
   // decode and switchback triggers
   // ****************************************
   assign pmr_wr = I_WR && (I_ADDR == `PMR_OFS);
   assign key_wr = I_WR && (I_ADDR == `KEY_OFS);
   assign cfg_wr = I_WR && (I_ADDR == `MEM_CFG_OFS);
   assign any_act = |act_q;
   // RULE4: enabled and recognized interrupt
   assign sb_int = switchback_en_q && I_EXT_INT_VECTOR && I_EXT_INT_EN;
   assign sb_tx = switchback_en_q && (I_UART0_TX_START || I_UART1_TX_START);
   // RULE5: receive waits for instruction start
   assign sb_rx = rx_pend_q && I_INSTR_START;
   assign sb_any = sb_int || sb_tx || sb_rx;
   // RULE13: lock divide during serial activity while switchback is enabled
   assign div_wr_ok = pmr_wr && (I_WDATA[`PMR_CD_HI:`PMR_CD_LO] != `CD_RSVD) && !(switchback_en_q && any_act);
   // RULE6: disable only while on RC
   assign xtal_off_set = pmr_wr && I_WDATA[`PMR_XT_DIS] && !osc_source_sel_q && !crystal_disable_q;
   // RULE8: each restart clears ready
   assign xt_restart = xtal_off_set || I_PD_EXIT;

   // ****************************************
   // power management register
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         clk_div_q <= `CD_DIV4;
      end
      // RULE3: forced return to divide by 4
      else if (sb_any)
      begin
         clk_div_q <= `CD_DIV4;
      end
      // RULE1: reserved code never stored
      else if (div_wr_ok)
      begin
         clk_div_q <= I_WDATA[`PMR_CD_HI:`PMR_CD_LO];
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         switchback_en_q <= 1'b0;
      end
      else if (pmr_wr)
      begin
         switchback_en_q <= I_WDATA[`PMR_SB_EN];
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         crystal_disable_q <= 1'b0;
      end
      // RULE6: set refused while on crystal
      else if (xtal_off_set)
      begin
         crystal_disable_q <= 1'b1;
      end
      // RULE7: clearing restarts the crystal
      else if (pmr_wr && !I_WDATA[`PMR_XT_DIS])
      begin
         crystal_disable_q <= 1'b0;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         osc_source_sel_q <= 1'b0;
      end
      else if (pmr_wr)
      begin
         // RULE10: crystal select needs ready
         osc_source_sel_q <= I_WDATA[`PMR_OSC] && (osc_source_sel_q || crystal_ready_q);
      end
   end

   // ****************************************
   // crystal warm-up
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         wu_cnt_q <= 16'h0000;
      end
      else if (xt_restart || crystal_ready_q || crystal_disable_q)
      begin
         wu_cnt_q <= 16'h0000;
      end
      else
      begin
         wu_cnt_q <= wu_cnt_q + 16'h0001;
      end
   end

   // counter resets on restart, so a second restart lengthens the warm-up
   assign ready_rise = !crystal_ready_q && !crystal_disable_q && !xt_restart &&
                       (wu_cnt_q == `XT_WARMUP_CYC - 16'h0001);

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      // RULE9: ready after reset
      if (!I_RST_N)
      begin
         crystal_ready_q <= 1'b1;
      end
      // RULE8: restart clears ready
      else if (xt_restart)
      begin
         crystal_ready_q <= 1'b0;
      end
      // RULE7: ready once warm-up done
      else if (ready_rise)
      begin
         crystal_ready_q <= 1'b1;
      end
   end

   // ****************************************
   // serial activity
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         act_q <= 4'h0;
      end
      else
      begin
         // RULE11: transmit activity, start wins over done
         act_q[`ST_TX0] <= I_UART0_TX_START || (act_q[`ST_TX0] && !I_UART0_TX_DONE_FLAG);
         act_q[`ST_TX1] <= I_UART1_TX_START || (act_q[`ST_TX1] && !I_UART1_TX_DONE_FLAG);
         // RULE12: receive activity, start wins over done
         act_q[`ST_RX0] <= I_UART0_RX_START || (act_q[`ST_RX0] && !I_UART0_RX_DONE_FLAG);
         act_q[`ST_RX1] <= I_UART1_RX_START || (act_q[`ST_RX1] && !I_UART1_RX_DONE_FLAG);
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rx_pend_q <= 1'b0;
      end
      // RULE5: remember start bit edge
      else if (switchback_en_q && (I_UART0_RX_START || I_UART1_RX_START))
      begin
         rx_pend_q <= 1'b1;
      end
      else if (I_INSTR_START)
      begin
         rx_pend_q <= 1'b0;
      end
   end

   // ****************************************
   // machine cycle counter
   // ****************************************
   // RULE1: cycle length from divide code
   assign mc_tick = (mc_cnt_q >= mc_last(clk_div_q));

   // compare is >= so a switch to a shorter length never overruns
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         mc_cnt_q <= 10'h000;
      end
      else if (mc_tick)
      begin
         mc_cnt_q <= 10'h000;
      end
      else
      begin
         mc_cnt_q <= mc_cnt_q + 10'h001;
      end
   end

   // ****************************************
   // timed access
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         unlock_q <= UNLOCK_IDLE;
         unlock_left_q <= 2'h0;
      end
      else
      begin
         unique case (unlock_q)
            UNLOCK_IDLE:
            begin
               if (key_wr && (I_WDATA == `KEY_FIRST))
               begin
                  unlock_q <= UNLOCK_ARMED;
               end
            end
            UNLOCK_ARMED:
            begin
               // RULE17: any write other than 55 or a repeated AA breaks the key
               if (key_wr && (I_WDATA == `KEY_SECOND))
               begin
                  unlock_q <= UNLOCK_OPEN;
                  unlock_left_q <= `KEY_WIN_MC;
               end
               else if (I_WR && !(key_wr && (I_WDATA == `KEY_FIRST)))
               begin
                  unlock_q <= UNLOCK_IDLE;
               end
            end
            UNLOCK_OPEN:
            begin
               // RULE15: window of three machine cycles
               if (mc_tick)
               begin
                  unlock_left_q <= unlock_left_q - 2'h1;
                  if (unlock_left_q == 2'h1)
                  begin
                     unlock_q <= UNLOCK_IDLE;
                  end
               end
            end
            default:
            begin
               unlock_q <= UNLOCK_IDLE;
            end
         endcase
      end
   end

   assign wait_refused = cfg_wr && (unlock_q != UNLOCK_OPEN);

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         wait_state_en_q <= 1'b0;
      end
      // RULE16: write only inside the window
      else if (cfg_wr && (unlock_q == UNLOCK_OPEN))
      begin
         wait_state_en_q <= I_WDATA[`MEM_WAIT_EN];
      end
   end

   // ****************************************
   // interrupts
   // ****************************************
   always_comb
   begin
      irq_evt = '0;
      irq_evt[`IRQ_SB] = sb_any;
      irq_evt[`IRQ_XT_RDY] = ready_rise;
      irq_evt[`IRQ_REFUSE] = wait_refused;
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         irq_stat_q <= '0;
      end
      else if (I_WR && (I_ADDR == `IRQ_CLR_OFS))
      begin
         irq_stat_q <= (irq_stat_q & ~I_WDATA[`IRQ_W-1:0]) | irq_evt;
      end
      else
      begin
         irq_stat_q <= irq_stat_q | irq_evt;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         irq_en_q <= '0;
      end
      else if (I_WR && (I_ADDR == `IRQ_EN_OFS))
      begin
         irq_en_q <= I_WDATA[`IRQ_W-1:0];
      end
   end

   // ****************************************
   // read port
   // ****************************************
   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rdata_q <= 8'h00;
      end
      else if (I_RD)
      begin
         unique case (I_ADDR)
            `PMR_OFS: rdata_q <= {clk_div_q, switchback_en_q, 1'b0, crystal_disable_q, osc_source_sel_q, 2'h0};
            `STATUS_OFS: rdata_q <= {3'h0, crystal_ready_q, act_q};
            `MEM_CFG_OFS: rdata_q <= {wait_state_en_q, 7'h00};
            `IRQ_STAT_OFS: rdata_q <= {5'h00, irq_stat_q};
            `IRQ_EN_OFS: rdata_q <= {5'h00, irq_en_q};
            default: rdata_q <= 8'h00;
         endcase
      end
      else
      begin
         rdata_q <= 8'h00;
      end
   end

   assign O_RDATA = rdata_q;
   assign O_CLK_DIV_SEL = clk_div_q;
   assign O_MC_TICK = mc_tick;
   assign O_XTAL_EN = !crystal_disable_q;
   assign O_OSC_SOURCE_SEL = osc_source_sel_q;
   assign O_CRYSTAL_READY = crystal_ready_q;
   assign O_WAIT_STATE_EN = wait_state_en_q;
   assign O_UNLOCK_WINDOW = (unlock_q == UNLOCK_OPEN);
   assign O_IRQ = |(irq_stat_q & irq_en_q);

   // ****************************************
   // assertions
   // ****************************************
   div_code_legal_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE1
      clk_div_q != `CD_RSVD) else $error("divide code reserved");

   div4_period_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE1
      (mc_tick && clk_div_q == `CD_DIV4) ##1 (clk_div_q == `CD_DIV4 && !mc_tick)[*3] ##1 (clk_div_q == `CD_DIV4)
      |-> mc_tick) else $error("divide by 4 cycle length wrong");

   int_switch_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE4
      (switchback_en_q && I_EXT_INT_VECTOR && I_EXT_INT_EN) |=> (clk_div_q == `CD_DIV4))
      else $error("interrupt switchback missing");

   rx_switch_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE5
      (switchback_en_q && I_UART0_RX_START && !I_INSTR_START) ##1 (!I_INSTR_START)[*4] ##1 I_INSTR_START
      |=> (clk_div_q == `CD_DIV4)) else $error("receive switchback missing");

   xtal_off_rc_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE6
      $rose(crystal_disable_q) |-> ($past(osc_source_sel_q) == 1'b0 && !crystal_ready_q))
      else $error("crystal disabled while on crystal");

   pd_ready_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE8
      I_PD_EXIT |=> !crystal_ready_q ##1 !crystal_ready_q) else $error("ready not cleared on restart");

   osc_gate_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE10
      $rose(osc_source_sel_q) |-> $past(crystal_ready_q)) else $error("crystal selected while not ready");

   tx_done_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE11
      (I_UART0_TX_DONE_FLAG && !I_UART0_TX_START) |=> !act_q[`ST_TX0]) else $error("tx activity not cleared");

   rx_act_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE12
      I_UART1_RX_START |=> act_q[`ST_RX1]) else $error("rx activity not set");

   div_lock_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE13
      (pmr_wr && switchback_en_q && any_act && !sb_any) |=> $stable(clk_div_q)) else $error("divide changed while busy");

   key_open_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE15
      (unlock_q == UNLOCK_ARMED && key_wr && I_WDATA == `KEY_SECOND) |=> (O_UNLOCK_WINDOW && unlock_left_q == 2'h3))
      else $error("key did not open window");

   wait_protect_a: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N) // RULE17
      $changed(wait_state_en_q) |-> $past(unlock_q == UNLOCK_OPEN && cfg_wr)) else $error("protected bit changed");

endmodule

// ### testbench/clock_divide_switchback_ctrl_tb_top.sv
// self-checking testbench of the clock-divide and switchback controller
`timescale 1ns/1ns
`include "clkctl_params.svh"
module clock_divide_switchback_ctrl_tb_top;
   // ****************************************
   // signals
   // ****************************************
   localparam int EV_VEC = 0, EV_INS = 1, EV_PD = 2, EV_T0 = 3, EV_R0 = 4, EV_TD0 = 5;
   localparam int EV_RD0 = 6, EV_T1 = 7, EV_R1 = 8, EV_TD1 = 9, EV_RD1 = 10;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic ext_en = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [10:0] ev = 11'h000;
   wire logic [7:0] rdata;
   wire logic [1:0] div;
   wire logic tick, xen, osc, rdy, wait_en, win, irq;
   int n_fail = 0;
   int check_count = 0;
   always #10 clk = ~clk;
   clock_divide_switchback_ctrl u_dut
   (
      .I_SYS_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s),
      .O_RDATA(rdata), .I_EXT_INT_VECTOR(ev[EV_VEC]), .I_EXT_INT_EN(ext_en), .I_INSTR_START(ev[EV_INS]),
      .I_PD_EXIT(ev[EV_PD]), .I_UART0_TX_START(ev[EV_T0]), .I_UART0_RX_START(ev[EV_R0]),
      .I_UART0_TX_DONE_FLAG(ev[EV_TD0]), .I_UART0_RX_DONE_FLAG(ev[EV_RD0]), .I_UART1_TX_START(ev[EV_T1]),
      .I_UART1_RX_START(ev[EV_R1]), .I_UART1_TX_DONE_FLAG(ev[EV_TD1]), .I_UART1_RX_DONE_FLAG(ev[EV_RD1]),
      .O_CLK_DIV_SEL(div), .O_MC_TICK(tick), .O_XTAL_EN(xen), .O_OSC_SOURCE_SEL(osc),
      .O_CRYSTAL_READY(rdy), .O_WAIT_STATE_EN(wait_en), .O_UNLOCK_WINDOW(win), .O_IRQ(irq)
   );
   // ****************************************
   // shared tasks
   // ****************************************
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_s <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_s <= 1'b0;
      #1;
   endtask
   task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk);
      rd_s <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_s <= 1'b0;
      #1;
      chk(name, {8'h00, rdata}, {8'h00, exp});
   endtask
   task automatic pulse(input int b);
      @(posedge clk);
      ev <= 11'h001 << b;
      @(posedge clk);
      ev <= 11'h000;
      #1;
   endtask
   // cycles between two machine-cycle ticks; the first tick resyncs after a divide change
   task automatic period(input int exp);
      int t;
      t = 0;
      while (tick !== 1'b1 && t < 2100)
      begin
         step();
         t++;
      end
      step();
      t = 1;
      while (tick !== 1'b1 && t < 2100)
      begin
         step();
         t++;
      end
      chk("mc_period", 16'(t), 16'(exp));
   endtask
   task automatic wait_rdy(output int n);
      n = 0;
      while (rdy !== 1'b1 && n < 1200)
      begin
         step();
         n++;
      end
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   // an open window ignores further key writes, so let it run out
   task automatic win_shut();
      int n;
      n = 0;
      while (win === 1'b1 && n < 100)
      begin
         step();
         n++;
      end
   endtask
   task automatic t_divide();
      chk("div_rst", {14'h0, div}, {14'h0, `CD_DIV4});
      rd_chk("status_rst", `STATUS_OFS, 8'h10);
      rd_chk("pmr_rst", `PMR_OFS, 8'h40);
      period(4);
      // software passes through divide-by-4 between slow settings
      reg_wr(`PMR_OFS, 8'h80);
      chk("div64", {14'h0, div}, {14'h0, `CD_DIV64});
      period(64);
      reg_wr(`PMR_OFS, 8'h40);
      reg_wr(`PMR_OFS, 8'hC0);
      chk("div1024", {14'h0, div}, {14'h0, `CD_DIV1024});
      period(1024);
      reg_wr(`PMR_OFS, 8'h40);
      reg_wr(`PMR_OFS, 8'h00);
      chk("div_rsvd", {14'h0, div}, {14'h0, `CD_DIV4});
   endtask
   task automatic t_switchback();
      reg_wr(`PMR_OFS, 8'hA0);
      ext_en <= 1'b0;
      pulse(EV_VEC);
      chk("sw_int_off", {14'h0, div}, {14'h0, `CD_DIV64});
      ext_en <= 1'b1;
      pulse(EV_VEC);
      chk("sw_int_on", {14'h0, div}, {14'h0, `CD_DIV4});
      rd_chk("irq_sw", `IRQ_STAT_OFS, 8'h01);
      reg_wr(`PMR_OFS, 8'hA0);
      pulse(EV_R0);
      repeat (3) step();
      chk("sw_rx_wait", {14'h0, div}, {14'h0, `CD_DIV64});
      pulse(EV_INS);
      chk("sw_rx_instr", {14'h0, div}, {14'h0, `CD_DIV4});
      rd_chk("rx0_busy", `STATUS_OFS, 8'h11);
      reg_wr(`PMR_OFS, 8'hE0);
      chk("div_locked", {14'h0, div}, {14'h0, `CD_DIV4});
      pulse(EV_RD0);
      rd_chk("rx0_done", `STATUS_OFS, 8'h10);
      reg_wr(`PMR_OFS, 8'hE0);
      chk("div_free", {14'h0, div}, {14'h0, `CD_DIV1024});
      pulse(EV_T1);
      chk("sw_tx", {14'h0, div}, {14'h0, `CD_DIV4});
      pulse(EV_TD1);
      reg_wr(`PMR_OFS, 8'h40);
      pulse(EV_T0);
      pulse(EV_T1);
      pulse(EV_R1);
      rd_chk("act_all", `STATUS_OFS, 8'h1E);
      pulse(EV_TD0);
      pulse(EV_TD1);
      rd_chk("tx_done", `STATUS_OFS, 8'h14);
      pulse(EV_RD1);
      rd_chk("rx1_done", `STATUS_OFS, 8'h10);
   endtask
   task automatic t_crystal();
      int n;
      reg_wr(`IRQ_CLR_OFS, 8'h07);
      reg_wr(`PMR_OFS, 8'h48);
      step();
      chk("xtal_off", {15'h0, xen}, 16'h0000);
      chk("rdy_clr", {15'h0, rdy}, 16'h0000);
      reg_wr(`PMR_OFS, 8'h44);
      chk("osc_refused", {15'h0, osc}, 16'h0000);
      chk("xtal_on", {15'h0, xen}, 16'h0001);
      wait_rdy(n);
      chk("warmup", {15'h0, n >= 1000 && n <= 1100}, 16'h0001);
      rd_chk("irq_rdy", `IRQ_STAT_OFS, 8'h02);
      reg_wr(`PMR_OFS, 8'h44);
      chk("osc_taken", {15'h0, osc}, 16'h0001);
      reg_wr(`PMR_OFS, 8'h4C);
      chk("xoff_refused", {15'h0, xen}, 16'h0001);
      reg_wr(`PMR_OFS, 8'h40);
      pulse(EV_PD);
      chk("rdy_pd", {15'h0, rdy}, 16'h0000);
      wait_rdy(n);
      chk("rdy_back", {15'h0, rdy}, 16'h0001);
   endtask
   task automatic t_timed();
      int n;
      int t;
      reg_wr(`IRQ_CLR_OFS, 8'h07);
      reg_wr(`MEM_CFG_OFS, 8'h80);
      chk("ws_locked", {15'h0, wait_en}, 16'h0000);
      rd_chk("irq_refuse", `IRQ_STAT_OFS, 8'h04);
      // software key, first value then second
      reg_wr(`KEY_OFS, `KEY_FIRST);
      reg_wr(`KEY_OFS, `KEY_SECOND);
      chk("win_open", {15'h0, win}, 16'h0001);
      reg_wr(`MEM_CFG_OFS, 8'h80);
      rd_chk("ws_set", `MEM_CFG_OFS, 8'h80);
      win_shut();
      // fresh key for a full window
      reg_wr(`KEY_OFS, `KEY_FIRST);
      reg_wr(`KEY_OFS, `KEY_SECOND);
      n = 0;
      t = 0;
      while (win === 1'b1 && n < 100)
      begin
         if (tick === 1'b1)
            t++;
         step();
         n++;
      end
      chk("win_ticks", 16'(t), 16'h0003);
      reg_wr(`MEM_CFG_OFS, 8'h00);
      chk("ws_kept", {15'h0, wait_en}, 16'h0001);
      reg_wr(`KEY_OFS, `KEY_FIRST);
      reg_wr(`PMR_OFS, 8'h40);
      reg_wr(`KEY_OFS, `KEY_SECOND);
      chk("win_broken", {15'h0, win}, 16'h0000);
      reg_wr(`KEY_OFS, `KEY_FIRST);
      reg_wr(`KEY_OFS, `KEY_FIRST);
      reg_wr(`KEY_OFS, `KEY_SECOND);
      reg_wr(`MEM_CFG_OFS, 8'h00);
      chk("ws_cleared", {15'h0, wait_en}, 16'h0000);
      win_shut();
   endtask
   // interrupt, mask, clear and odd addresses
   task automatic t_irq();
      reg_wr(`IRQ_EN_OFS, 8'h07);
      reg_wr(`IRQ_CLR_OFS, 8'h07);
      chk("irq_low", {15'h0, irq}, 16'h0000);
      reg_wr(`MEM_CFG_OFS, 8'h80);
      chk("irq_high", {15'h0, irq}, 16'h0001);
      reg_wr(`IRQ_EN_OFS, 8'h03);
      chk("irq_masked", {15'h0, irq}, 16'h0000);
      rd_chk("irq_en_rb", `IRQ_EN_OFS, 8'h03);
      reg_wr(`IRQ_CLR_OFS, 8'h04);
      rd_chk("irq_cleared", `IRQ_STAT_OFS, 8'h00);
      reg_wr(8'h10, 8'hFF);
      rd_chk("unmapped", 8'h10, 8'h00);
      rd_chk("key_wo", `KEY_OFS, 8'h00);
      rd_chk("clr_wo", `IRQ_CLR_OFS, 8'h00);
      rd_chk("ws_untouched", `MEM_CFG_OFS, 8'h00);
   endtask
   // ****************************************
   // run control
   // ****************************************
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // the whole run is a few thousand cycles; this limit is far above it
   initial
   begin
      #1000000;
      n_fail++;
      $display("mismatch watchdog expected done seen hang");
      summarize();
   end
   initial
   begin
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      t_divide();
      t_switchback();
      t_crystal();
      t_timed();
      t_irq();
      summarize();
   end
endmodule
